// ---- dual_serial_port_pkg.sv ----
// Shared constants for the dual serial port: register indices, control bit
// positions, reset values, bit-rate counts and state encodings.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
`default_nettype none
package dual_serial_port_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [9:0] IDX_S0_CTRL = 10'h098;
    localparam logic [9:0] IDX_S0_BUF = 10'h099;
    localparam logic [9:0] IDX_S1_CTRL = 10'h0c0;
    localparam logic [9:0] IDX_S1_BUF = 10'h0c1;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h0e0;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;
    localparam logic [9:0] IDX_T1_RELOAD = 10'h0e2;
    // Control register bit positions
    localparam int CTRL_MP = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TI = 1;
    localparam int CTRL_RI = 0;
    // Interrupt status and mask bit positions
    localparam int IRQ_TX0 = 0;
    localparam int IRQ_RX0 = 1;
    localparam int IRQ_TX1 = 2;
    localparam int IRQ_RX1 = 3;
    // Values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // Port 1 has no timer: its variable-rate reload is fixed
    localparam logic [7:0] PORT1_RELOAD = 8'hf0;
    // Bit-rate counts, in system clock cycles, ticks or bits
    localparam logic [3:0] SYNC_DIV_SLOW = 4'hc;
    localparam logic [3:0] SYNC_DIV_FAST = 4'h4;
    localparam logic [8:0] FIXED_TICK_DIV = 9'h004;
    localparam logic [8:0] RELOAD_SPAN = 9'h100;
    localparam logic [3:0] START_MID_TICK = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] ASYNC_RX_SAMPLES = 4'h9;
    localparam logic [3:0] ASYNC8_TX_BITS = 4'ha;
    localparam logic [3:0] ASYNC9_TX_BITS = 4'hb;
    typedef enum logic [1:0] {
        MODE_SYNC = 2'b00,
        MODE_ASYNC8 = 2'b01,
        MODE_ASYNC9_FIXED = 2'b10,
        MODE_ASYNC9_VAR = 2'b11
    } mode_type;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ASYNC = 2'b01,
        TX_SYNC = 2'b11
    } tx_state_type;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_ASYNC = 2'b11,
        RX_SYNC = 2'b10
    } rx_state_type;
endpackage : dual_serial_port_pkg
`default_nettype wire

// ---- rate_tick.sv ----
// Oversampling tick generator: one-cycle pulse every period_i clocks.
// Assumes period_i is at least 4 and changes only between frames.
`default_nettype none
module rate_tick (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [8:0] period_i,
    output logic tick_o
);
    import dual_serial_port_pkg::*;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // Count up and wrap; a shortened period takes effect at once
    always_comb begin
        if (cnt_r >= period_i - 9'h001) begin
            cnt_nxt = 9'h000;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 9'h001;
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= 9'h000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;
endmodule : rate_tick
`default_nettype wire

// ---- dual_serial_port.sv ----
// Two serial ports behind a classic Wishbone slave, with a sticky interrupt.
// Assumes one 40 MHz clock, synchronous reset and pins synchronised here.
`default_nettype none
module serial_channel #(
    parameter bit TIMER_RATE = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_ctrl_i,
    input wire logic wr_buf_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] reload_i,
    input wire logic rxd_i,
    output logic [7:0] ctrl_o,
    output logic [7:0] buf_o,
    output logic tx_evt_o,
    output logic rx_evt_o,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o
);
    import dual_serial_port_pkg::*;
    logic [7:0] ctrl_r, ctrl_nxt, buf_r, buf_nxt;
    tx_state_type tx_st_r, tx_st_nxt;
    rx_state_type rx_st_r, rx_st_nxt;
    logic [10:0] tx_sh_r, tx_sh_nxt;
    logic [8:0] rx_sh_r, rx_sh_nxt;
    logic [3:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
    logic [3:0] tx_tick_r, tx_tick_nxt, rx_tick_r, rx_tick_nxt;
    logic [3:0] ph_r, ph_nxt;
    logic txd_r, txd_nxt, rxd_out_r, rxd_out_nxt, rxd_oe_r, rxd_oe_nxt;
    logic tx_evt_r, tx_evt_nxt, rx_evt_r, rx_evt_nxt;
    logic rx_s1_r, rx_s2_r, rx_s3_r;
    logic tick;
    logic accept;
    logic [3:0] sync_div, sync_half;
    logic [7:0] rate_reload;
    logic [8:0] tick_period;
    mode_type mode;

    assign mode = mode_type'(ctrl_r[7:6]);
    assign sync_div = ctrl_r[CTRL_MP] ? SYNC_DIV_FAST : SYNC_DIV_SLOW;
    assign sync_half = {1'b0, sync_div[3:1]};
    // Port 0 follows the timer reload; port 1 runs at a fixed reload
    assign rate_reload = TIMER_RATE ? reload_i : PORT1_RELOAD;
    assign tick_period = (mode == MODE_ASYNC9_FIXED) ? FIXED_TICK_DIV
                         : RELOAD_SPAN - {1'b0, rate_reload};
    // Multiprocessor filter: same test on stop bit or ninth bit
    assign accept = !ctrl_r[CTRL_RI] && (!ctrl_r[CTRL_MP] || rx_s2_r);

    rate_tick u_rate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .period_i(tick_period),
        .tick_o(tick)
    );

    // Transmit, receive and register next-state logic
    always_comb begin
        ctrl_nxt = ctrl_r;
        buf_nxt = buf_r;
        tx_st_nxt = tx_st_r;
        rx_st_nxt = rx_st_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        rx_cnt_nxt = rx_cnt_r;
        tx_tick_nxt = tx_tick_r;
        rx_tick_nxt = rx_tick_r;
        ph_nxt = ph_r;
        txd_nxt = txd_r;
        rxd_out_nxt = rxd_out_r;
        rxd_oe_nxt = rxd_oe_r;
        tx_evt_nxt = 1'b0;
        rx_evt_nxt = 1'b0;
        if (wr_ctrl_i) begin
            ctrl_nxt = wdata_i;
        end
        if (wr_buf_i) begin
            buf_nxt = wdata_i;
        end
        case (tx_st_r)
            TX_IDLE: begin
                // A running synchronous reception owns the bit clock
                if (rx_st_r != RX_SYNC) begin
                    txd_nxt = 1'b1;
                end
                rxd_oe_nxt = 1'b0;
                if (wr_buf_i && mode == MODE_SYNC) begin
                    tx_st_nxt = TX_SYNC;
                    tx_sh_nxt = {3'b111, wdata_i};
                    tx_cnt_nxt = SYNC_BITS;
                    ph_nxt = 4'h0;
                end else if (wr_buf_i) begin
                    tx_st_nxt = TX_ASYNC;
                    // Frame LSB first: start, data, ninth or stop, stop
                    tx_sh_nxt = {1'b1, (mode == MODE_ASYNC8) ? 1'b1 : ctrl_r[CTRL_TB8],
                                 wdata_i, 1'b0};
                    tx_cnt_nxt = (mode == MODE_ASYNC8) ? ASYNC8_TX_BITS : ASYNC9_TX_BITS;
                    tx_tick_nxt = 4'h0;
                end
            end
            TX_ASYNC: begin
                if (tick) begin
                    tx_tick_nxt = tx_tick_r + 4'h1;
                    if (tx_tick_r == 4'h0 && tx_cnt_r != 4'h0) begin
                        txd_nxt = tx_sh_r[0];
                        tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
                        tx_cnt_nxt = tx_cnt_r - 4'h1;
                        if (tx_cnt_r == 4'h1) begin
                            ctrl_nxt[CTRL_TI] = 1'b1;
                            tx_evt_nxt = 1'b1;
                        end
                    end
                    if (tx_tick_r == LAST_TICK && tx_cnt_r == 4'h0) begin
                        tx_st_nxt = TX_IDLE;
                    end
                end
            end
            TX_SYNC: begin
                ph_nxt = (ph_r == sync_div - 4'h1) ? 4'h0 : ph_r + 4'h1;
                if (ph_r == 4'h0) begin
                    txd_nxt = 1'b0;
                    rxd_out_nxt = tx_sh_r[0];
                    rxd_oe_nxt = 1'b1;
                end
                if (ph_r == sync_half) begin
                    txd_nxt = 1'b1;
                end
                if (ph_r == sync_div - 4'h1) begin
                    tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
                    tx_cnt_nxt = tx_cnt_r - 4'h1;
                    if (tx_cnt_r == 4'h1) begin
                        ctrl_nxt[CTRL_TI] = 1'b1;
                        tx_evt_nxt = 1'b1;
                        tx_st_nxt = TX_IDLE;
                        rxd_oe_nxt = 1'b0;
                    end
                end
            end
            default: begin
                tx_st_nxt = TX_IDLE;
            end
        endcase
        case (rx_st_r)
            RX_IDLE: begin
                if (mode == MODE_SYNC) begin
                    if (ctrl_r[CTRL_REN] && !ctrl_r[CTRL_RI] && tx_st_r == TX_IDLE
                        && !wr_buf_i) begin
                        rx_st_nxt = RX_SYNC;
                        rx_cnt_nxt = SYNC_BITS;
                        ph_nxt = 4'h0;
                    end
                end else if (ctrl_r[CTRL_REN] && rx_s3_r && !rx_s2_r) begin
                    rx_st_nxt = RX_START;
                    rx_tick_nxt = 4'h0;
                end
            end
            RX_START: begin
                if (tick) begin
                    rx_tick_nxt = rx_tick_r + 4'h1;
                    if (rx_tick_r == START_MID_TICK) begin
                        // A start bit gone high by mid-bit was a glitch
                        rx_st_nxt = rx_s2_r ? RX_IDLE : RX_ASYNC;
                        rx_tick_nxt = 4'h0;
                        rx_cnt_nxt = ASYNC_RX_SAMPLES;
                    end
                end
            end
            RX_ASYNC: begin
                if (tick) begin
                    rx_tick_nxt = rx_tick_r + 4'h1;
                    if (rx_tick_r == LAST_TICK) begin
                        rx_sh_nxt = {rx_s2_r, rx_sh_r[8:1]};
                        rx_cnt_nxt = rx_cnt_r - 4'h1;
                        if (rx_cnt_r == 4'h1) begin
                            rx_st_nxt = RX_IDLE;
                            if (accept) begin
                                buf_nxt = rx_sh_r[8:1];
                                ctrl_nxt[CTRL_RB8] = rx_s2_r;
                                ctrl_nxt[CTRL_RI] = 1'b1;
                                rx_evt_nxt = 1'b1;
                            end
                        end
                    end
                end
            end
            RX_SYNC: begin
                ph_nxt = (ph_r == sync_div - 4'h1) ? 4'h0 : ph_r + 4'h1;
                rxd_oe_nxt = 1'b0;
                if (ph_r == 4'h0) begin
                    txd_nxt = 1'b0;
                end
                if (ph_r == sync_half) begin
                    txd_nxt = 1'b1;
                    rx_sh_nxt = {rx_s2_r, rx_sh_r[8:1]};
                end
                if (ph_r == sync_div - 4'h1) begin
                    rx_cnt_nxt = rx_cnt_r - 4'h1;
                    if (rx_cnt_r == 4'h1) begin
                        buf_nxt = rx_sh_r[8:1];
                        ctrl_nxt[CTRL_RI] = 1'b1;
                        rx_evt_nxt = 1'b1;
                        rx_st_nxt = RX_IDLE;
                    end
                end
                // Half duplex: a buffer write takes the line from reception
                if (wr_buf_i) begin
                    rx_st_nxt = RX_IDLE;
                    txd_nxt = 1'b1;
                    ph_nxt = 4'h0;
                end
            end
            default: begin
                rx_st_nxt = RX_IDLE;
            end
        endcase
    end

    // State registers; hardware only sets the flags, a control write or reset clears them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
            buf_r <= BUF_RESET;
            tx_st_r <= TX_IDLE;
            rx_st_r <= RX_IDLE;
            tx_sh_r <= 11'h7ff;
            rx_sh_r <= 9'h000;
            tx_cnt_r <= 4'h0;
            rx_cnt_r <= 4'h0;
            tx_tick_r <= 4'h0;
            rx_tick_r <= 4'h0;
            ph_r <= 4'h0;
            txd_r <= 1'b1;
            rxd_out_r <= 1'b1;
            rxd_oe_r <= 1'b0;
            tx_evt_r <= 1'b0;
            rx_evt_r <= 1'b0;
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            buf_r <= buf_nxt;
            tx_st_r <= tx_st_nxt;
            rx_st_r <= rx_st_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            tx_tick_r <= tx_tick_nxt;
            rx_tick_r <= rx_tick_nxt;
            ph_r <= ph_nxt;
            txd_r <= txd_nxt;
            rxd_out_r <= rxd_out_nxt;
            rxd_oe_r <= rxd_oe_nxt;
            tx_evt_r <= tx_evt_nxt;
            rx_evt_r <= rx_evt_nxt;
            rx_s1_r <= rxd_i;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
        end
    end

    assign ctrl_o = ctrl_r;
    assign buf_o = buf_r;
    assign tx_evt_o = tx_evt_r;
    assign rx_evt_o = rx_evt_r;
    assign rxd_o = rxd_out_r;
    assign rxd_oe_o = rxd_oe_r;
    assign txd_o = txd_r;

    // Checks on the port's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    flag_keep_a: assert property (ctrl_r[CTRL_TI] && !wr_ctrl_i |=> ctrl_r[CTRL_TI])
        else $error("transmit flag cleared by hardware");
    mp9_filter_a: assert property ($rose(ctrl_r[CTRL_RI]) && !$past(wr_ctrl_i)
        && ctrl_r[7] && ctrl_r[CTRL_MP] |-> ctrl_r[CTRL_RB8])
        else $error("receive flag raised for ninth bit zero");
    mp8_stop_a: assert property ($rose(ctrl_r[CTRL_RI]) && !$past(wr_ctrl_i)
        && mode == MODE_ASYNC8 && ctrl_r[CTRL_MP] |-> ctrl_r[CTRL_RB8])
        else $error("receive flag raised with bad stop bit");
    ren_gate_a: assert property (!ctrl_r[CTRL_REN] && rx_st_r == RX_IDLE
        |=> rx_st_r == RX_IDLE)
        else $error("reception started while disabled");
    ninth_tx_a: assert property (tx_st_r == TX_IDLE && wr_buf_i && ctrl_r[7]
        |=> tx_sh_r[9] == $past(ctrl_r[CTRL_TB8]))
        else $error("ninth transmit bit not taken from control");
    sync_slow_a: assert property ($fell(txd_r) && tx_st_r == TX_SYNC && !ctrl_r[CTRL_MP]
        && tx_cnt_r > 4'h1 && !wr_ctrl_i |-> ##12 $fell(txd_r))
        else $error("slow synchronous bit period not twelve clocks");
    clk_idle_a: assert property (tx_st_r == TX_IDLE && rx_st_r == RX_IDLE
        && mode == MODE_SYNC |=> txd_r)
        else $error("bit clock not idle high");
    buf_reset_a: assert property ($past(rst_i) |-> buf_r == BUF_RESET)
        else $error("data buffer not zero after reset");
    sync_tx_done_a: assert property (tx_st_r == TX_IDLE && wr_buf_i && mode == MODE_SYNC
        && ctrl_r[CTRL_MP] && !wr_ctrl_i ##1 !wr_ctrl_i [*8] |-> ##25 tx_evt_r)
        else $error("synchronous transmit flag late");
    rx_halt_a: assert property (mode == MODE_SYNC && ctrl_r[CTRL_RI] && rx_st_r == RX_IDLE
        |=> rx_st_r == RX_IDLE)
        else $error("synchronous reception ran with flag set");

    sync_tx_c: cover property (tx_st_r == TX_SYNC ##[1:200] tx_evt_r);
    async_rx_c: cover property (rx_st_r == RX_ASYNC ##[1:1000] rx_evt_r);
    mp_drop_c: cover property (rx_st_r == RX_ASYNC && rx_cnt_r == 4'h1 && tick
        && rx_tick_r == LAST_TICK && !accept);
endmodule : serial_channel

module dual_serial_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic port0_receive_pin_i,
    output logic port0_receive_pin_o,
    output logic port0_receive_pin_oe_o,
    output logic port0_transmit_pin_o,
    input wire logic port1_receive_pin_i,
    output logic port1_receive_pin_o,
    output logic port1_receive_pin_oe_o,
    output logic port1_transmit_pin_o
);
    import dual_serial_port_pkg::*;
    logic ack_r, ack_nxt, irq_r, irq_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [3:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic [7:0] t1_reload_r, t1_reload_nxt;
    logic [9:0] idx;
    logic wr;
    logic [7:0] ctrl0, buf0, ctrl1, buf1;
    logic tx0_evt, rx0_evt, tx1_evt, rx1_evt;
    logic [3:0] events;

    assign idx = adr_i[11:2];
    // Writes land on the acknowledging edge, byte lane 0 only
    assign wr = cyc_i && stb_i && we_i && ack_r && sel_i[0] && adr_i[31:12] == 20'h00000;
    assign events = {rx1_evt, tx1_evt, rx0_evt, tx0_evt};

    // Both ports share one design; port 0 takes the timer rate
    serial_channel #(.TIMER_RATE(1'b1)) u_port0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_ctrl_i(wr && idx == IDX_S0_CTRL),
        .wr_buf_i(wr && idx == IDX_S0_BUF),
        .wdata_i(dat_i[7:0]),
        .reload_i(t1_reload_r),
        .rxd_i(port0_receive_pin_i),
        .ctrl_o(ctrl0),
        .buf_o(buf0),
        .tx_evt_o(tx0_evt),
        .rx_evt_o(rx0_evt),
        .rxd_o(port0_receive_pin_o),
        .rxd_oe_o(port0_receive_pin_oe_o),
        .txd_o(port0_transmit_pin_o)
    );

    serial_channel #(.TIMER_RATE(1'b0)) u_port1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_ctrl_i(wr && idx == IDX_S1_CTRL),
        .wr_buf_i(wr && idx == IDX_S1_BUF),
        .wdata_i(dat_i[7:0]),
        .reload_i(t1_reload_r),
        .rxd_i(port1_receive_pin_i),
        .ctrl_o(ctrl1),
        .buf_o(buf1),
        .tx_evt_o(tx1_evt),
        .rx_evt_o(rx1_evt),
        .rxd_o(port1_receive_pin_o),
        .rxd_oe_o(port1_receive_pin_oe_o),
        .txd_o(port1_transmit_pin_o)
    );

    // Bus answer, read mux and interrupt registers; a new event beats a clear
    always_comb begin
        ack_nxt = cyc_i && stb_i && !ack_r;
        dat_nxt = dat_r;
        if (cyc_i && stb_i && !ack_r) begin
            dat_nxt = 32'h00000000;
            if (adr_i[31:12] == 20'h00000) begin
                case (idx)
                    IDX_S0_CTRL: dat_nxt[7:0] = ctrl0;
                    IDX_S0_BUF: dat_nxt[7:0] = buf0;
                    IDX_S1_CTRL: dat_nxt[7:0] = ctrl1;
                    IDX_S1_BUF: dat_nxt[7:0] = buf1;
                    IDX_IRQ_STAT: dat_nxt[3:0] = irq_stat_r;
                    IDX_IRQ_MASK: dat_nxt[3:0] = irq_mask_r;
                    IDX_T1_RELOAD: dat_nxt[7:0] = t1_reload_r;
                    default: dat_nxt = 32'h00000000;
                endcase
            end
        end
        irq_stat_nxt = irq_stat_r;
        irq_mask_nxt = irq_mask_r;
        t1_reload_nxt = t1_reload_r;
        if (wr && idx == IDX_IRQ_STAT) begin
            irq_stat_nxt = irq_stat_r & ~dat_i[3:0];
        end
        if (wr && idx == IDX_IRQ_MASK) begin
            irq_mask_nxt = dat_i[3:0];
        end
        if (wr && idx == IDX_T1_RELOAD) begin
            t1_reload_nxt = dat_i[7:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
        irq_nxt = |(irq_stat_r & irq_mask_r);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
            irq_stat_r <= IRQ_RESET;
            irq_mask_r <= IRQ_RESET;
            t1_reload_r <= RELOAD_RESET;
            irq_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            t1_reload_r <= t1_reload_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign irq_o = irq_r;

    bus_ack_c: cover property (@(posedge clk_i) disable iff (rst_i) ack_r && we_i);
endmodule : dual_serial_port
`default_nettype wire

// ---- serial_peer.sv ----
// Far serial device: sends and captures asynchronous frames.
// Assumes the line idles high and is called just after a clock edge.
`default_nettype none
module serial_peer (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got;
    initial line_o = 1'b1;
    // Start, data LSB first, ninth bit, stop; idle level is high
    task automatic send(input logic [8:0] v, input int bits);
        for (int i = 0; i < 11; i++) begin
            line_o <= (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : v[i-1];
            repeat (bits) @(posedge clk_i);
        end
    endtask : send
    // Mid-bit sampling of data and ninth bit
    task automatic take(input int bits);
        @(negedge line_i);
        repeat (bits / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bits) @(posedge clk_i);
            got[i] = line_i;
        end
    endtask : take
endmodule : serial_peer
`default_nettype wire

// ---- dual_serial_port_test.sv ----
// Bench for the dual serial port: Wishbone tasks and a serial peer on port 0.
// Port 1 is looped back on itself so that its pins are driven.
`default_nettype none
module dual_serial_port_test;
    import dual_serial_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:2] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] dat_o;
    logic ack_o, irq_o, rx0, tx0, d0, oe0, rx1, tx1, d1, oe1, peer_line;
    logic [7:0] v;
    time t0;
    int failures = 0;
    int samples_checked = 0;
    // Wire levels follow whoever drives the data pin
    assign rx0 = oe0 ? d0 : peer_line;
    assign rx1 = oe1 ? d1 : tx1;
    dual_serial_port u_dual_serial_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .irq_o(irq_o), .port0_receive_pin_i(rx0), .port0_receive_pin_o(d0),
        .port0_receive_pin_oe_o(oe0), .port0_transmit_pin_o(tx0), .port1_receive_pin_i(rx1),
        .port1_receive_pin_o(d1), .port1_receive_pin_oe_o(oe1), .port1_transmit_pin_o(tx1));
    serial_peer u_serial_peer (.clk_i(clk_i), .line_i(tx0), .line_o(peer_line));
    initial forever #12.5 clk_i = ~clk_i;
    task automatic complete_run();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Classic cycle: hold the request until ack is sampled high at a rising edge,
    // take the read data at that same edge and release there
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {20'h00000, idx};
        dat <= {24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        check(q, exp);
    endtask : rd
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr
    // Interrupt level is registered, so look at it away from the edge
    task automatic irq_is(input logic e);
        @(negedge clk_i);
        check({31'h0, irq_o}, {31'h0, e});
        @(posedge clk_i);
    endtask : irq_is
    // Mode 0: data is taken at each rising edge of the bit clock
    task automatic grab();
        for (int i = 0; i < 8; i++) begin
            @(posedge tx0);
            v[i] = d0;
            if (i == 0) t0 = $time;
        end
    endtask : grab
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_S0_CTRL, 32'h0);
        rd(IDX_S0_BUF, 32'h0);
        rd(10'h3ff, 32'h0);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_S0_CTRL, 8'hb8);
        fork
            u_serial_peer.take(64);
            wr(IDX_S0_BUF, 8'ha5);
        join
        check({23'h0, u_serial_peer.got}, 32'h1a5);
        repeat (64) @(posedge clk_i);
        rd(IDX_S0_CTRL, 32'hba);
        irq_is(1'b1);
        wr(IDX_IRQ_STAT, 8'h01);
        wr(IDX_S0_CTRL, 8'hb8);
        u_serial_peer.send(9'h03c, 64);
        rd(IDX_S0_CTRL, 32'hb8);
        u_serial_peer.send(9'h15a, 64);
        rd(IDX_S0_CTRL, 32'hbd);
        rd(IDX_S0_BUF, 32'h5a);
        rd(IDX_IRQ_STAT, 32'h2);
        irq_is(1'b0);
        // Port 0 rate from the timer reload: 256 - 0xf8 gives 8 clocks a tick
        wr(IDX_T1_RELOAD, 8'hf8);
        rd(IDX_T1_RELOAD, 32'hf8);
        wr(IDX_S0_CTRL, 8'hc0);
        fork
            u_serial_peer.take(128);
            wr(IDX_S0_BUF, 8'h3c);
        join
        check({23'h0, u_serial_peer.got}, 32'h03c);
        repeat (256) @(posedge clk_i);
        wr(IDX_S0_CTRL, 8'h20);
        fork
            grab();
            wr(IDX_S0_BUF, 8'h96);
        join
        check({24'h0, v}, 32'h96);
        check(32'(($time - t0) / 25), 32'd28);
        check({31'h0, oe0}, 32'h1);
        repeat (2) @(posedge clk_i);
        rd(IDX_S0_CTRL, 32'h22);
        check({31'h0, oe0}, 32'h0);
        wr(IDX_S0_CTRL, 8'h00);
        fork
            grab();
            wr(IDX_S0_BUF, 8'h69);
        join
        check({24'h0, v}, 32'h69);
        check(32'(($time - t0) / 25), 32'd84);
        // Port 1 in 8-bit mode with filtering hears its own frame
        wr(IDX_S1_CTRL, 8'h70);
        wr(IDX_S1_BUF, 8'hc3);
        repeat (2700) @(posedge clk_i);
        rd(IDX_S1_CTRL, 32'h77);
        rd(IDX_S1_BUF, 32'hc3);
        rd(IDX_IRQ_STAT, 32'hf);
        complete_run();
    end
    // Cut a hang short well beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        complete_run();
    end
endmodule : dual_serial_port_test
`default_nettype wire
